//--- logic/lah_host_regs.sv
// host register file and interrupt logic of the link adaptor
`timescale 1ns/1ps
module lah_host_regs (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic [1:0] register_select,
   input wire logic read_write_dir,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe_n,
   input wire logic packet_received,
   input wire logic [7:0] packet_data,
   input wire logic ack_received,
   output logic send_data,
   output logic [7:0] send_byte,
   output logic send_ack,
   output logic receive_int,
   output logic transmit_int
);
   import lah_pkg::*;

   //------------------------------------------------------------
   // strobe decode
   //------------------------------------------------------------
   lah_bus_s bus;
   lah_access_s access;
   logic cs_fall;
   logic cs_rise;
   logic rx_valid;
   logic tx_ready;
   logic rx_enable;
   logic tx_enable;
   logic [7:0] rx_buffer;
   logic rd_rx_data;
   logic wr_tx_data;
   logic wr_rx_stat;
   logic wr_tx_stat;
   logic next_rx_valid;
   logic next_tx_ready;
   logic next_rx_enable;
   logic next_tx_enable;
   logic [1:0] rd_sel;
   logic rd_dir;

   assign bus = '{chip_select_n, register_select, read_write_dir, host_data_in};

   lah_strobe u_strobe (
      .clock(clock),
      .rst_b(rst_b),
      .bus(bus),
      .fall(cs_fall),
      .rise(cs_rise),
      .access(access)
   );

   function automatic logic hit(input lah_access_s a, input logic [1:0] s, input logic r);
      hit = (a.sel == s) && (a.rd == r);
   endfunction : hit

   // reads take effect at chip select release, after data was presented
   // invalid combinations and writes to receive data fall through
   assign rd_rx_data = cs_rise && hit(access, sel_data, 1'b1);
   assign wr_tx_data = cs_rise && hit(access, sel_tx_data, 1'b0);
   assign wr_rx_stat = cs_rise && hit(access, sel_rx_status, 1'b0);
   assign wr_tx_stat = cs_rise && hit(access, sel_tx_status, 1'b0);

   // host may move select and direction once chip select is low
   assign rd_sel = cs_fall ? register_select : access.sel;
   assign rd_dir = cs_fall ? read_write_dir : access.rd;

   //------------------------------------------------------------
   // receive side
   //------------------------------------------------------------
   // a packet landing with the read: the new arrival wins
   always_comb begin
      next_rx_valid = rx_valid;
      if (rd_rx_data) begin
         next_rx_valid = 1'b0;
      end
      if (packet_received) begin
         next_rx_valid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_valid <= rx_valid_reset;
      end else begin
         rx_valid <= next_rx_valid;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_buffer <= read_idle;
      end else if (packet_received) begin
         rx_buffer <= packet_data;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         send_ack <= 1'b0;
      end else begin
         send_ack <= rd_rx_data;
      end
   end

   //------------------------------------------------------------
   // transmit side
   //------------------------------------------------------------
   // ack and write together: the ack wins; only a write to a busy buffer meets it
   always_comb begin
      next_tx_ready = tx_ready;
      if (wr_tx_data) begin
         next_tx_ready = 1'b0;
      end
      if (ack_received) begin
         next_tx_ready = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_ready <= tx_ready_reset;
      end else begin
         tx_ready <= next_tx_ready;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         send_data <= 1'b0;
         send_byte <= read_idle;
      end else begin
         send_data <= wr_tx_data;
         if (wr_tx_data) begin
            send_byte <= host_data_in;
         end
      end
   end

   //------------------------------------------------------------
   // status enables
   //------------------------------------------------------------
   // enable written in the same edge as the interrupt update
   assign next_rx_enable = wr_rx_stat ? host_data_in[enable_bit] : rx_enable;
   assign next_tx_enable = wr_tx_stat ? host_data_in[enable_bit] : tx_enable;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_enable <= enable_reset;
         tx_enable <= enable_reset;
      end else begin
         rx_enable <= next_rx_enable;
         tx_enable <= next_tx_enable;
      end
   end

   //------------------------------------------------------------
   // interrupts, registered from next state
   //------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         receive_int <= 1'b0;
         transmit_int <= 1'b0;
      end else begin
         receive_int <= next_rx_valid & next_rx_enable;
         transmit_int <= next_tx_ready & next_tx_enable;
      end
   end

   //------------------------------------------------------------
   // read data path
   //------------------------------------------------------------
   // status bits 2-7 always zero, stronger than required
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         host_data_out <= read_idle;
         host_data_oe_n <= 1'b1;
      end else begin
         host_data_oe_n <= chip_select_n | ~rd_dir;
         case (rd_sel)
            sel_data: host_data_out <= rx_buffer;
            sel_rx_status: host_data_out <= {6'h00, rx_enable, rx_valid};
            sel_tx_status: host_data_out <= {6'h00, tx_enable, tx_ready};
            default: host_data_out <= read_idle;
         endcase
      end
   end
endmodule : lah_host_regs

//--- logic/lah_pkg.sv
// package of constants and types for the link adaptor host register block
//------------------------------------------------------------
// Summary of operation
// - link data packet sets receive valid flag
// - only data read or reset clears valid
// - status bits 2-7 read as zero
// - interrupt enables written and read back
// - receive interrupt is enable and valid
// - receive data read drops receive interrupt
// - receive data read sends acknowledge packet
// - transmit write sends packet, clears ready
// - transmit data read returns undefined, no effect
// - ready means empty, reset sets it
// - ready stays low until ack arrives
// - transmit interrupt is enable and ready
// - select bits plus direction pick register
// - writes to receive data are ignored
// - latch select on fall, data on rise
//------------------------------------------------------------
package lah_pkg;
   localparam logic [1:0] sel_data = 2'h0;
   localparam logic [1:0] sel_tx_data = 2'h1;
   localparam logic [1:0] sel_rx_status = 2'h2;
   localparam logic [1:0] sel_tx_status = 2'h3;
   localparam int flag_bit = 0;
   localparam int enable_bit = 1;
   localparam logic rx_valid_reset = 1'b0;
   localparam logic tx_ready_reset = 1'b1;
   localparam logic enable_reset = 1'b0;
   localparam logic [7:0] read_idle = 8'h00;

   typedef struct packed {
      logic chip_select_n;
      logic [1:0] register_select;
      logic read_write_dir;
      logic [7:0] host_data_bus;
   } lah_bus_s;

   typedef struct packed {
      logic [1:0] sel;
      logic rd;
   } lah_access_s;
endpackage : lah_pkg

//--- logic/lah_strobe.sv
// chip select edge detector and access latch
`timescale 1ns/1ps
module lah_strobe (
   input wire logic clock,
   input wire logic rst_b,
   input wire lah_pkg::lah_bus_s bus,
   output logic fall,
   output logic rise,
   output lah_pkg::lah_access_s access
);
   import lah_pkg::*;
   logic cs_n_q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cs_n_q <= 1'b1;
      end else begin
         cs_n_q <= bus.chip_select_n;
      end
   end

   assign fall = cs_n_q & ~bus.chip_select_n;
   assign rise = ~cs_n_q & bus.chip_select_n;

   // select and direction held from the falling edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         access <= '0;
      end else if (fall) begin
         access.sel <= bus.register_select;
         access.rd <= bus.read_write_dir;
      end
   end
endmodule : lah_strobe

//--- verif/lah_check_assertions.sv
// port assertions for the host register block
`timescale 1ns/1ps
module lah_check (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic [1:0] register_select,
   input wire logic read_write_dir,
   input wire logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe_n,
   input wire logic packet_received,
   input wire logic ack_received,
   input wire logic send_data,
   input wire logic [7:0] send_byte,
   input wire logic send_ack,
   input wire logic receive_int,
   input wire logic transmit_int
);
   logic cs_q, rise, rd_rx, wr_tx, wr_st, bad, sel_hi;
   logic [2:0] acc;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) cs_q <= 1'b1;
      else cs_q <= chip_select_n;
   end
   // unreset on purpose: only read after a fall
   always_ff @(posedge clock) begin
      if (cs_q && !chip_select_n) acc <= {register_select, read_write_dir};
   end
   assign rise = !cs_q && chip_select_n;
   assign rd_rx = rise && acc == 3'h1;
   assign wr_tx = rise && acc == 3'h2;
   assign wr_st = rise && acc[2] && !acc[0];
   assign bad = rise && (acc == 3'h0 || acc == 3'h3);
   // select as latched at the fall, live only in the fall cycle
   assign sel_hi = (cs_q && !chip_select_n) ? register_select[1] : acc[2];
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_ack; rd_rx |=> send_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_send; wr_tx |=> send_data && send_byte == $past(host_data_in); endproperty
   a_send: assert property (p_send) else $error("send wrong");
   property p_rx_drop; send_ack && !$past(packet_received) |-> !receive_int; endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("rx int held");
   property p_tx_drop; send_data |-> !transmit_int; endproperty
   a_tx_drop: assert property (p_tx_drop) else $error("tx int held");
   property p_tx_rise; $rose(transmit_int) |-> $past(ack_received) || $past(wr_st); endproperty
   a_tx_rise: assert property (p_tx_rise) else $error("tx int rose");
   property p_rx_rise; $rose(receive_int) |-> $past(packet_received) || $past(wr_st);
   endproperty
   a_rx_rise: assert property (p_rx_rise) else $error("rx int rose");
   property p_bad; bad |=> !send_ack && !send_data; endproperty
   a_bad: assert property (p_bad) else $error("invalid acted");
   property p_zero; !host_data_oe_n && $past(sel_hi) |-> host_data_out[7:2] == 6'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("status bits set");
   c_ack: cover property (rd_rx ##1 send_ack);
   c_send: cover property (send_data ##[1:20] ack_received);
   c_bad: cover property (bad);
endmodule : lah_check
bind lah_host_regs lah_check chk (.clock(clock), .rst_b(rst_b), .chip_select_n(chip_select_n),
   .register_select(register_select), .read_write_dir(read_write_dir),
   .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
   .packet_received(packet_received), .ack_received(ack_received), .send_data(send_data),
   .send_byte(send_byte), .send_ack(send_ack), .receive_int(receive_int),
   .transmit_int(transmit_int));

//--- verif/lah_link.sv
// link side stand-in: injects packets, acks sent data
`timescale 1ns/1ps
module lah_link (
   input wire logic clock,
   input wire logic send_data,
   input wire logic inject,
   input wire logic [7:0] inject_byte,
   input wire logic [3:0] delay,
   output logic packet_received,
   output logic [7:0] packet_data,
   output logic ack_received
);
   logic [4:0] cnt = 5'h00;
   always_ff @(posedge clock) begin
      packet_received <= inject;
      // idle data is inverted so a stale byte never looks valid
      packet_data <= inject ? inject_byte : ~inject_byte;
      ack_received <= cnt == 5'h01;
      cnt <= send_data ? 5'(delay) + 5'h01 : cnt - 5'(cnt != 5'h00);
   end
endmodule : lah_link

//--- verif/testbench.sv
// bench: host register accesses against the link stand-in
`timescale 1ns/1ps
module testbench;
   import lah_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   lah_bus_s bus = '{1'b1, 2'h0, 1'b1, 8'h00};
   logic inject = 1'b0;
   logic [7:0] ib = 8'h00;
   logic [3:0] delay = 4'h0;
   logic [7:0] dout, pdata, sbyte, rd;
   logic oe_n, pkt, ack, sdata, sack, rint, tint;
   logic oe;
   int n_errors = 0;
   int checks_done = 0;
   int n_acks = 0;
   always #20 clock = ~clock;
   // pulses settle after the rising edge, so count them on the falling one
   always @(negedge clock) begin
      if (sack) begin
         n_acks++;
      end
   end
   lah_host_regs uut (.clock(clock), .rst_b(rst_b), .chip_select_n(bus.chip_select_n),
      .register_select(bus.register_select), .read_write_dir(bus.read_write_dir),
      .host_data_in(bus.host_data_bus), .host_data_out(dout), .host_data_oe_n(oe_n),
      .packet_received(pkt), .packet_data(pdata), .ack_received(ack), .send_data(sdata),
      .send_byte(sbyte), .send_ack(sack), .receive_int(rint), .transmit_int(tint));
   lah_link link (.clock(clock), .send_data(sdata), .inject(inject), .inject_byte(ib),
      .delay(delay), .packet_received(pkt), .packet_data(pdata), .ack_received(ack));
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // cs low 3 cycles, high at least 3: above the 2-cycle minimum
   task automatic acc(input logic [1:0] sel, input logic dir, input logic [7:0] wd);
      @(negedge clock);
      bus <= '{1'b0, sel, dir, wd};
      repeat (3) @(negedge clock);
      rd = dout;
      oe = oe_n;
      bus.chip_select_n <= 1'b1;
      repeat (2) @(negedge clock);
   endtask : acc
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   // tests need about 125 cycles; 3000-cycle limit, over twentyfold margin
   initial begin
      #120000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (3) @(negedge clock);
      rst_b <= 1'b1;
      acc(sel_rx_status, 1'b1, 8'hff);
      chk("rx status", 8'h00, rd);
      acc(sel_tx_status, 1'b1, 8'hff);
      chk("tx status", 8'h01, rd);
      chk("ints", 8'h00, {6'h0, rint, tint});
      acc(sel_rx_status, 1'b0, 8'h02);
      acc(sel_tx_status, 1'b0, 8'h02);
      acc(sel_tx_status, 1'b1, 8'hff);
      chk("tx status", 8'h03, rd);
      chk("ints", 8'h01, {6'h0, rint, tint});
      $display("test reset done");
      @(negedge clock);
      inject <= 1'b1;
      ib <= 8'ha5;
      @(negedge clock);
      inject <= 1'b0;
      acc(sel_rx_status, 1'b1, 8'hff);
      chk("rx status", 8'h03, rd);
      chk("ints", 8'h03, {6'h0, rint, tint});
      acc(sel_rx_status, 1'b0, 8'h00);
      chk("ints", 8'h01, {6'h0, rint, tint});
      chk("drive", 8'h01, {7'h0, oe});
      acc(sel_data, 1'b0, 8'h5a);
      acc(sel_tx_data, 1'b1, 8'hff);
      chk("tx data", read_idle, rd);
      acc(sel_rx_status, 1'b0, 8'h02);
      chk("ints", 8'h03, {6'h0, rint, tint});
      chk("acks", 8'h00, 8'(n_acks));
      acc(sel_data, 1'b1, 8'hff);
      chk("rx data", 8'ha5, rd);
      chk("drive", 8'h00, {7'h0, oe});
      chk("acks", 8'h01, 8'(n_acks));
      chk("ints", 8'h01, {6'h0, rint, tint});
      $display("test receive done");
      for (int i = 0; i < 2; i++) begin
         delay <= 4'(i * 8);
         acc(sel_tx_data, 1'b0, 8'h3c + 8'(i));
         chk("send byte", 8'h3c + 8'(i), sbyte);
         chk("ints", 8'h00, {6'h0, rint, tint});
         repeat (12) @(negedge clock);
         chk("ints", 8'h01, {6'h0, rint, tint});
      end
      $display("test transmit done");
      inject <= 1'b1;
      @(negedge clock);
      inject <= 1'b0;
      repeat (2) @(negedge clock);
      chk("ints", 8'h03, {6'h0, rint, tint});
      rst_b <= 1'b0;
      repeat (3) @(negedge clock);
      rst_b <= 1'b1;
      chk("ints", 8'h00, {6'h0, rint, tint});
      acc(sel_rx_status, 1'b1, 8'hff);
      chk("rx status", 8'h00, rd);
      acc(sel_tx_status, 1'b1, 8'hff);
      chk("tx status", 8'h01, rd);
      $display("test reset again done");
      conclude();
   end
endmodule : testbench
